// >>> gpio_pkg.sv
// constants for the six-bit general-purpose port
// assumes a 32-bit axi4-lite register bus, one register per aligned word
package gpio_pkg;
    localparam int         PIN_COUNT      = 6;
    localparam int         ADDR_WIDTH     = 5;
    localparam logic [4:0] OFF_PIN_DATA   = 5'h00;
    localparam logic [4:0] OFF_DIRECTION  = 5'h04;
    localparam logic [4:0] OFF_PULL       = 5'h08;
    localparam logic [4:0] OFF_SLEW       = 5'h0c;
    localparam logic [4:0] OFF_DRIVE      = 5'h10;
    localparam logic [5:0] RST_PIN_DATA   = 6'h00;
    localparam logic [5:0] RST_DIRECTION  = 6'h00;
    localparam logic [5:0] RST_PULL       = 6'h00;
    localparam logic [5:0] RST_SLEW       = 6'h00;
    localparam logic [5:0] RST_DRIVE      = 6'h00;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage : gpio_pkg

// >>> port_ctrl_reg.sv
// one six-bit port control register with a byte-lane-0 write strobe
// assumes the bus slave gives a one-cycle write pulse
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_reg #(
    parameter logic [5:0] RESET_VALUE = 6'h00
) (
    input  wire logic       aclk,     // bus clock
    input  wire logic       aresetn,  // sync reset, active low
    input  wire logic       wr_en,    // one-cycle write pulse
    input  wire logic [5:0] wr_data,  // low six bits of write data
    output logic      [5:0] value_q   // stored value
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_q <= RESET_VALUE;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
endmodule : port_ctrl_reg
`default_nettype wire

// >>> pin_cell.sv
// per-pin output stage: driver, pull and pad controls
// assumes pull-down is only requested by a pin-interrupt block
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
    input  wire logic aclk,        // bus clock
    input  wire logic aresetn,     // sync reset, active low
    input  wire logic latch,       // data latch bit
    input  wire logic dir_out,     // direction bit
    input  wire logic pull_en,     // pull enable bit
    input  wire logic slew_en,     // slew enable bit
    input  wire logic drive_hi,    // drive strength bit
    input  wire logic irq_pulldn,  // interrupt edge/pin select active
    output logic      pad_o_q,     // driven level
    output logic      pad_oe_q,    // driver enable
    output logic      pull_up_q,   // pull-up on
    output logic      pull_dn_q,   // pull-down on
    output logic      slew_q,      // slew limiting on
    output logic      drive_q      // high drive on
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_o_q   <= 1'b0;
            pad_oe_q  <= 1'b0;
            pull_up_q <= 1'b0;
            pull_dn_q <= 1'b0;
            slew_q    <= 1'b0;
            drive_q   <= 1'b0;
        end else begin
            pad_o_q   <= dir_out & latch;
            pad_oe_q  <= dir_out;
            pull_up_q <= !dir_out && pull_en && !irq_pulldn;
            pull_dn_q <= !dir_out && pull_en && irq_pulldn;
            slew_q    <= dir_out & slew_en;
            drive_q   <= dir_out & drive_hi;
        end
    end
endmodule : pin_cell
`default_nettype wire

// >>> six_bit_gpio_port.sv
// six-bit gpio port behind an axi4-lite slave
// assumes pin inputs already synchronous to aclk; one clock, sync reset
//
// Operation
// - an input bit reads back the sampled pin level.
// - an output bit reads back the last value written to its latch.
// - a data write loads every latch bit, input pins included.
// - an output pin drives its latch level.
// - reset clears the latches and leaves every pin undriven with pulls off.
// - direction zero turns the driver off and reads return the pin.
// - direction one turns the driver on and reads return the latch.
// - pull enable turns on the pull-up of an input pin; outputs keep pulls off.
// - pull-down is used only when the pin-interrupt selects are active.
// - slew enable limits slew on output pins and does nothing on inputs.
// - drive bit selects low or high drive on outputs, no effect on inputs.
`timescale 1ns/1ps
`default_nettype none
module six_bit_gpio_port (
    input  wire logic        aclk,         // 50 mhz bus clock
    input  wire logic        aresetn,      // sync reset, active low
    input  wire logic [4:0]  s_axi_awaddr, // write address
    input  wire logic [2:0]  s_axi_awprot, // unused protection
    input  wire logic        s_axi_awvalid,// write address valid
    output logic             s_axi_awready,// write address ready
    input  wire logic [31:0] s_axi_wdata,  // write data
    input  wire logic [3:0]  s_axi_wstrb,  // byte enables
    input  wire logic        s_axi_wvalid, // write data valid
    output logic             s_axi_wready, // write data ready
    output logic [1:0]       s_axi_bresp,  // write response
    output logic             s_axi_bvalid, // write response valid
    input  wire logic        s_axi_bready, // write response ready
    input  wire logic [4:0]  s_axi_araddr, // read address
    input  wire logic [2:0]  s_axi_arprot, // unused protection
    input  wire logic        s_axi_arvalid,// read address valid
    output logic             s_axi_arready,// read address ready
    output logic [31:0]      s_axi_rdata,  // read data
    output logic [1:0]       s_axi_rresp,  // read response
    output logic             s_axi_rvalid, // read data valid
    input  wire logic        s_axi_rready, // read data ready
    input  wire logic [5:0]  pad_i,        // pin levels
    input  wire logic [5:0]  irq_pulldn,   // interrupt selects per pin
    output logic      [5:0]  pad_o,        // pin drive levels
    output logic      [5:0]  pad_oe,       // pin driver enables
    output logic      [5:0]  pull_up,      // pull-up enables
    output logic      [5:0]  pull_dn,      // pull-down enables
    output logic      [5:0]  slew_lim,     // slew limiting enables
    output logic      [5:0]  drive_high    // high drive enables
);
    logic        aw_held_q;
    logic [4:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write;
    logic        wr_data_en;
    logic        wr_dir_en;
    logic        wr_pull_en;
    logic        wr_slew_en;
    logic        wr_drive_en;
    logic        wr_hit;
    logic [5:0]  pin_data_q;
    logic [5:0]  direction_q;
    logic [5:0]  pull_q;
    logic [5:0]  slew_q;
    logic [5:0]  drive_q;
    logic [5:0]  rd_value;
    logic        rd_hit;
    logic [5:0]  pin_read;

    // write address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 5'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    // decode; only byte lane 0 carries implemented bits
    always_comb begin
        wr_data_en  = 1'b0;
        wr_dir_en   = 1'b0;
        wr_pull_en  = 1'b0;
        wr_slew_en  = 1'b0;
        wr_drive_en = 1'b0;
        wr_hit      = 1'b1;
        if (aw_addr_q[4:2] == gpio_pkg::OFF_PIN_DATA[4:2]) begin
            wr_data_en = do_write && w_strb_q[0];
        end else if (aw_addr_q[4:2] == gpio_pkg::OFF_DIRECTION[4:2]) begin
            wr_dir_en = do_write && w_strb_q[0];
        end else if (aw_addr_q[4:2] == gpio_pkg::OFF_PULL[4:2]) begin
            wr_pull_en = do_write && w_strb_q[0];
        end else if (aw_addr_q[4:2] == gpio_pkg::OFF_SLEW[4:2]) begin
            wr_slew_en = do_write && w_strb_q[0];
        end else if (aw_addr_q[4:2] == gpio_pkg::OFF_DRIVE[4:2]) begin
            wr_drive_en = do_write && w_strb_q[0];
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // response code only moves with a new write, so it holds while bvalid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= gpio_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bresp <= wr_hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
        end
    end

    // upper write bits are simply not wired into the registers
    port_ctrl_reg #(.RESET_VALUE(gpio_pkg::RST_PIN_DATA)) u_data (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_data_en),
        .wr_data (w_data_q[5:0]),
        .value_q (pin_data_q)
    );
    port_ctrl_reg #(.RESET_VALUE(gpio_pkg::RST_DIRECTION)) u_dir (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_dir_en),
        .wr_data (w_data_q[5:0]),
        .value_q (direction_q)
    );
    port_ctrl_reg #(.RESET_VALUE(gpio_pkg::RST_PULL)) u_pull (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_pull_en),
        .wr_data (w_data_q[5:0]),
        .value_q (pull_q)
    );
    // slew reset value fixed here; firmware should still set it
    port_ctrl_reg #(.RESET_VALUE(gpio_pkg::RST_SLEW)) u_slew (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_slew_en),
        .wr_data (w_data_q[5:0]),
        .value_q (slew_q)
    );
    port_ctrl_reg #(.RESET_VALUE(gpio_pkg::RST_DRIVE)) u_drive (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_drive_en),
        .wr_data (w_data_q[5:0]),
        .value_q (drive_q)
    );

    // one cell per implemented pin; upper lanes have no pad at all
    pin_cell u_pin0 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch      (pin_data_q[0]),
        .dir_out    (direction_q[0]),
        .pull_en    (pull_q[0]),
        .slew_en    (slew_q[0]),
        .drive_hi   (drive_q[0]),
        .irq_pulldn (irq_pulldn[0]),
        .pad_o_q    (pad_o[0]),
        .pad_oe_q   (pad_oe[0]),
        .pull_up_q  (pull_up[0]),
        .pull_dn_q  (pull_dn[0]),
        .slew_q     (slew_lim[0]),
        .drive_q    (drive_high[0])
    );
    pin_cell u_pin1 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch      (pin_data_q[1]),
        .dir_out    (direction_q[1]),
        .pull_en    (pull_q[1]),
        .slew_en    (slew_q[1]),
        .drive_hi   (drive_q[1]),
        .irq_pulldn (irq_pulldn[1]),
        .pad_o_q    (pad_o[1]),
        .pad_oe_q   (pad_oe[1]),
        .pull_up_q  (pull_up[1]),
        .pull_dn_q  (pull_dn[1]),
        .slew_q     (slew_lim[1]),
        .drive_q    (drive_high[1])
    );
    pin_cell u_pin2 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch      (pin_data_q[2]),
        .dir_out    (direction_q[2]),
        .pull_en    (pull_q[2]),
        .slew_en    (slew_q[2]),
        .drive_hi   (drive_q[2]),
        .irq_pulldn (irq_pulldn[2]),
        .pad_o_q    (pad_o[2]),
        .pad_oe_q   (pad_oe[2]),
        .pull_up_q  (pull_up[2]),
        .pull_dn_q  (pull_dn[2]),
        .slew_q     (slew_lim[2]),
        .drive_q    (drive_high[2])
    );
    pin_cell u_pin3 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch      (pin_data_q[3]),
        .dir_out    (direction_q[3]),
        .pull_en    (pull_q[3]),
        .slew_en    (slew_q[3]),
        .drive_hi   (drive_q[3]),
        .irq_pulldn (irq_pulldn[3]),
        .pad_o_q    (pad_o[3]),
        .pad_oe_q   (pad_oe[3]),
        .pull_up_q  (pull_up[3]),
        .pull_dn_q  (pull_dn[3]),
        .slew_q     (slew_lim[3]),
        .drive_q    (drive_high[3])
    );
    pin_cell u_pin4 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch      (pin_data_q[4]),
        .dir_out    (direction_q[4]),
        .pull_en    (pull_q[4]),
        .slew_en    (slew_q[4]),
        .drive_hi   (drive_q[4]),
        .irq_pulldn (irq_pulldn[4]),
        .pad_o_q    (pad_o[4]),
        .pad_oe_q   (pad_oe[4]),
        .pull_up_q  (pull_up[4]),
        .pull_dn_q  (pull_dn[4]),
        .slew_q     (slew_lim[4]),
        .drive_q    (drive_high[4])
    );
    pin_cell u_pin5 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .latch      (pin_data_q[5]),
        .dir_out    (direction_q[5]),
        .pull_en    (pull_q[5]),
        .slew_en    (slew_q[5]),
        .drive_hi   (drive_q[5]),
        .irq_pulldn (irq_pulldn[5]),
        .pad_o_q    (pad_o[5]),
        .pad_oe_q   (pad_oe[5]),
        .pull_up_q  (pull_up[5]),
        .pull_dn_q  (pull_dn[5]),
        .slew_q     (slew_lim[5]),
        .drive_q    (drive_high[5])
    );

    // per bit: pin level for inputs, latch contents for outputs
    assign pin_read = (direction_q & pin_data_q) | (~direction_q & pad_i);

    // read mux; pin level read directly, it is taken as already synchronous
    always_comb begin
        rd_value = 6'h00;
        rd_hit   = 1'b1;
        if (s_axi_araddr[4:2] == gpio_pkg::OFF_PIN_DATA[4:2]) begin
            rd_value = pin_read;
        end else if (s_axi_araddr[4:2] == gpio_pkg::OFF_DIRECTION[4:2]) begin
            rd_value = direction_q;
        end else if (s_axi_araddr[4:2] == gpio_pkg::OFF_PULL[4:2]) begin
            rd_value = pull_q;
        end else if (s_axi_araddr[4:2] == gpio_pkg::OFF_SLEW[4:2]) begin
            rd_value = slew_q;
        end else if (s_axi_araddr[4:2] == gpio_pkg::OFF_DRIVE[4:2]) begin
            rd_value = drive_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // pin level is caught at the address handshake and then held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gpio_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= {26'h000_0000, rd_value};
            s_axi_rresp <= rd_hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
        end
    end
endmodule : six_bit_gpio_port
`default_nettype wire

// >>> gpio_port_assertions.sv
// checker for the six-bit port: bus answers and pin control outputs
// assumes it is bound to six_bit_gpio_port, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker (
    input wire logic        aclk,          // clock
    input wire logic        aresetn,       // reset, low
    input wire logic        s_axi_awready, // aw ready
    input wire logic        s_axi_bvalid,  // b valid
    input wire logic        s_axi_bready,  // b ready
    input wire logic [1:0]  s_axi_bresp,   // b resp
    input wire logic [4:0]  s_axi_araddr,  // ar addr
    input wire logic        s_axi_arvalid, // ar valid
    input wire logic        s_axi_arready, // ar ready
    input wire logic        s_axi_rvalid,  // r valid
    input wire logic [31:0] s_axi_rdata,   // r data
    input wire logic [1:0]  s_axi_rresp,   // r resp
    input wire logic [5:0]  irq_pulldn,    // pull-down select
    input wire logic [5:0]  pad_o,         // level
    input wire logic [5:0]  pad_oe,        // enable
    input wire logic [5:0]  pull_up,       // pull-up
    input wire logic [5:0]  pull_dn,       // pull-down
    input wire logic [5:0]  slew_lim,      // slew
    input wire logic [5:0]  drive_high     // drive
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence bad_read;
        ar_taken ##0 (s_axi_araddr[4:2] > 3'h4);
    endsequence
    a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_unmapped_read: assert property (bad_read |=> s_axi_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
        else $error("upper read bits not zero");
    a_drive_gated: assert property ((pad_o & ~pad_oe) == 6'h0)
        else $error("level driven without enable");
    a_pull_off_out: assert property (((pull_up | pull_dn) & pad_oe) == 6'h0)
        else $error("pull on while driving");
    a_pulldn_select: assert property (((pull_dn & ~$past(irq_pulldn)) |
        (pull_up & $past(irq_pulldn))) == 6'h0) else $error("wrong pull device");
    a_pad_ctrl_out: assert property (((slew_lim | drive_high) & ~pad_oe) == 6'h0)
        else $error("pad control on input pin");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        (pad_oe | pull_up | pull_dn) == 6'h0) else $error("pins active after reset");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp) && !s_axi_awready) else $error("write response dropped");
endmodule : gpio_port_checker
bind six_bit_gpio_port gpio_port_checker u_chk (.aclk, .aresetn, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .irq_pulldn, .pad_o,
    .pad_oe, .pull_up, .pull_dn, .slew_lim, .drive_high);
`default_nettype wire

// >>> gpio_pins_model.sv
// board side of the six pins: resolves each pin's level
// assumes board drivers are kept off pins the port drives
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
    input wire logic       aclk,    // clock for float pattern
    input wire logic [5:0] pad_o,   // port drive level
    input wire logic [5:0] pad_oe,  // port drive enable
    input wire logic [5:0] pull_up, // pull-up on
    input wire logic [5:0] pull_dn, // pull-down on
    input wire logic [5:0] ext_val, // board drive level
    input wire logic [5:0] ext_en,  // board drives pin
    output logic     [5:0] pad_lvl  // resolved level
);
    logic [5:0] float_q = 6'h15;
    // an undriven pin wanders, so a stale value is never read back
    always_ff @(posedge aclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pad_oe[i]) pad_lvl[i] = pad_o[i];
            else if (ext_en[i]) pad_lvl[i] = ext_val[i];
            else if (pull_up[i]) pad_lvl[i] = 1'b1;
            else if (pull_dn[i]) pad_lvl[i] = 1'b0;
            else pad_lvl[i] = float_q[i];
        end
    end
endmodule : gpio_pins_model
`default_nettype wire

// >>> tb_six_bit_gpio_port.sv
// self-checking bench: axi4-lite master, random pin setups, board model
// assumes gpio_pkg offsets and a one-cycle lag on pin outputs
`timescale 1ns/1ps
`default_nettype none
module tb_six_bit_gpio_port;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    // board holds a known pattern on every pin until the random loop takes over
    logic [5:0]  pad_i, irq_pulldn = 6'h0, ext_val = 6'h2a, ext_en = 6'h3f;
    logic        late_b = 1'b0;
    logic [5:0]  pad_o, pad_oe, pull_up, pull_dn, slew_lim, drive_high;
    logic [15:0] rnd = 16'h005e;
    int          errors = 0, compares = 0;
    six_bit_gpio_port uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pad_i, .irq_pulldn, .pad_o, .pad_oe, .pull_up, .pull_dn,
        .slew_lim, .drive_high);
    gpio_pins_model pins (.aclk, .pad_o, .pad_oe, .pull_up, .pull_dn, .ext_val, .ext_en,
        .pad_lvl(pad_i));
    always #10 aclk = ~aclk;
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    // input bits see the board, else the pull; floating bits are masked by the caller
    function automatic logic [5:0] exp_data(input logic [5:0] dir, lat, en, ev, pul, irq);
        return (dir & lat) | (~dir & ((en & ev) | (~en & pul & ~irq)));
    endfunction : exp_data
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask : check
    task automatic c6(input string w, input logic [5:0] e, input logic [5:0] g);
        check(w, {26'h0, e}, {26'h0, g});
    endtask : c6
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // a late bready makes the slave hold its response
        s_axi_bready <= !late_b;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #1000000;
        errors++;
        finish_test();
    end
    initial begin
        logic [31:0] d;
        logic [5:0]  dir, lat, pul, sl, dr, irq, en, ev, m;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(5'(i * 4), gpio_pkg::RESP_OKAY, d);
            check("reset value", (i == 0) ? 32'h2a : 32'h0, d);
        end
        // direction before data, so the data readback shows the latch
        for (int i = 4; i >= 0; i--) begin
            wr(5'(i * 4), 32'hffffffff, gpio_pkg::RESP_OKAY);
            rd(5'(i * 4), gpio_pkg::RESP_OKAY, d);
            check("upper bits", 32'h3f, d);
        end
        rd(5'h14, gpio_pkg::RESP_SLVERR, d);
        check("unmapped read", 32'h0, d);
        wr(5'h18, 32'h0, gpio_pkg::RESP_SLVERR);
        for (int k = 0; k < 40; k++) begin
            rnd = lfsr(rnd);
            {dir, lat} = rnd[11:0];
            rnd = lfsr(rnd);
            {pul, sl} = rnd[11:0];
            rnd = lfsr(rnd);
            {dr, irq} = rnd[11:0];
            rnd = lfsr(rnd);
            {en, ev} = rnd[11:0];
            late_b = rnd[15];
            if (k < 2) dir = {6{k[0]}};
            en = en & ~dir;
            wr(gpio_pkg::OFF_PIN_DATA, {26'h0, lat}, gpio_pkg::RESP_OKAY);
            wr(gpio_pkg::OFF_DIRECTION, {26'h0, dir}, gpio_pkg::RESP_OKAY);
            wr(gpio_pkg::OFF_PULL, {26'h0, pul}, gpio_pkg::RESP_OKAY);
            wr(gpio_pkg::OFF_SLEW, {26'h0, sl}, gpio_pkg::RESP_OKAY);
            wr(gpio_pkg::OFF_DRIVE, {26'h0, dr}, gpio_pkg::RESP_OKAY);
            irq_pulldn <= irq;
            ext_en <= en;
            ext_val <= ev;
            repeat (2) @(posedge aclk);
            c6("pad_oe", dir, pad_oe);
            c6("pad_o", dir & lat, pad_o);
            c6("pull_up", ~dir & pul & ~irq, pull_up);
            c6("pull_dn", ~dir & pul & irq, pull_dn);
            c6("slew_lim", dir & sl, slew_lim);
            c6("drive_high", dir & dr, drive_high);
            m = dir | en | pul;
            rd(gpio_pkg::OFF_PIN_DATA, gpio_pkg::RESP_OKAY, d);
            c6("data read", exp_data(dir, lat, en, ev, pul, irq) & m, d[5:0] & m);
        end
        ext_en <= 6'h0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        c6("pins after reset", 6'h0, pad_oe | pull_up | pull_dn);
        wr(gpio_pkg::OFF_DIRECTION, 32'h3f, gpio_pkg::RESP_OKAY);
        rd(gpio_pkg::OFF_PIN_DATA, gpio_pkg::RESP_OKAY, d);
        check("latch after reset", 32'h0, d);
        finish_test();
    end
endmodule : tb_six_bit_gpio_port
`default_nettype wire
